/* File: verilog/pdc_consts.svh */
/*
  constants for the port debounce clock select block: register byte
  addresses, field positions, reset values, source select codes and the
  strap capture delay.
  assumes inclusion from the design file and the bench top; definitions only.
*/
`ifndef PDC_CONSTS_SVH
`define PDC_CONSTS_SVH

// ==========================================================
// register byte addresses
`define PDC_ADDR_MODE_STATUS 32'h40000084
`define PDC_ADDR_DB_CLOCK_AB 32'h4000009C
`define PDC_ADDR_DB_CLOCK_CD 32'h400000A0
`define PDC_ADDR_DB_CLOCK_EF 32'h400000A4

// ==========================================================
// field positions
`define PDC_STATUS_WIDTH 8
`define PDC_SCAN_BIT 2
`define PDC_TEST_BIT 1
`define PDC_BOOT_BIT 0
`define PDC_LO_SEL_LSB 8
`define PDC_LO_DIV_LSB 0
`define PDC_HI_SEL_LSB 24
`define PDC_HI_DIV_LSB 16

// ==========================================================
// reset values
`define PDC_SEL_RST 3'h0
`define PDC_DIV_RST_A 8'h01
`define PDC_DIV_RST_B 8'h01
`define PDC_DIV_RST_C 8'h01
`define PDC_DIV_RST_D 8'h01
`define PDC_DIV_RST_E 8'h01
`define PDC_DIV_RST_F 8'h00

// ==========================================================
// source select codes, anything with bit 2 low is the ring oscillator
`define PDC_SEL_BUS 3'h4
`define PDC_SEL_INT 3'h5
`define PDC_SEL_EXT 3'h6
`define PDC_SEL_PLL 3'h7

// ==========================================================
// timing
`define PDC_STRAP_SETTLE 3'h4

`endif

/* File: verilog/pdc_pkg.sv */
/*
  types for the port debounce clock select block.
  assumes nothing beyond a SystemVerilog compiler.
*/
package pdc_pkg;

  typedef enum logic [2:0] {
    PDC_SRC_RING,
    PDC_SRC_BUS,
    PDC_SRC_INT,
    PDC_SRC_EXT,
    PDC_SRC_PLL
  } pdc_src_t;

endpackage

/* File: verilog/pdc_port_debounce_clock_select.sv */
/*
  port debounce clock select: six per-port debounce clock enables built
  from one of five sources and an 8-bit divider, plus the boot strap
  status register.
  assumes one system clock, oscillator and strap inputs asynchronous to it,
  and a register master that follows the plain strobe protocol.
*/
// Overview of operation
// RULE_01 - status register shows strap levels caught at boot
// RULE_02 - status is 8 bits, read only
// RULE_03 - bit2 scan, bit1 test, bit0 boot
// RULE_04 - first register serves ports A and B
// RULE_05 - port B select bits 26:24, shared encoding
// RULE_06 - port B divider bits 23:16
// RULE_07 - port A select bits 10:8
// RULE_08 - select 100 routes the bus clock
// RULE_09 - second register serves ports C and D
// RULE_10 - port D select bits 26:24
// RULE_11 - port D divider bits 23:16
// RULE_12 - port C select bits 10:8
// RULE_13 - port C divider bits 7:0
// RULE_14 - third register serves ports E and F
// RULE_15 - port F select bits 26:24
// RULE_16 - port F divider bits 23:16
// RULE_17 - port E select bits 10:8
// RULE_18 - port E divider bits 7:0
// RULE_19 - output is source divided, zero means undivided
// RULE_20 - reprogramming never makes runt pulses
`timescale 1ns/100ps
`include "pdc_consts.svh"

module pdc_port_debounce_clock_select (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clkEn,
  input wire logic [31:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  output logic [31:0] regRdData,
  input wire logic ringOscIn,
  input wire logic intOscIn,
  input wire logic extOscIn,
  input wire logic pllIn,
  input wire logic bootStrapLevel,
  input wire logic testStrapLevel,
  input wire logic scanStrapLevel,
  output logic [5:0] dbClkTick
);

  localparam int NPORT = 6;
  localparam int NASYNC = 7;
  localparam logic [7:0] DIV_RST [NPORT] = '{
    `PDC_DIV_RST_A, `PDC_DIV_RST_B, `PDC_DIV_RST_C,
    `PDC_DIV_RST_D, `PDC_DIV_RST_E, `PDC_DIV_RST_F
  };

  // ==========================================================
  // helpers

  // index 0..2 of the config register hit, 3 when none
  function automatic logic [1:0] cfgIndex(input logic [31:0] addr);
    logic [1:0] idx;
    idx = 2'h3;
    if (addr == `PDC_ADDR_DB_CLOCK_AB)
      idx = 2'h0;
    else if (addr == `PDC_ADDR_DB_CLOCK_CD)
      idx = 2'h1;
    else if (addr == `PDC_ADDR_DB_CLOCK_EF)
      idx = 2'h2;
    return idx;
  endfunction

  function automatic pdc_pkg::pdc_src_t srcKind(input logic [2:0] sel);
    pdc_pkg::pdc_src_t kind;
    kind = pdc_pkg::PDC_SRC_RING;
    if (sel == `PDC_SEL_BUS)
      kind = pdc_pkg::PDC_SRC_BUS;
    else if (sel == `PDC_SEL_INT)
      kind = pdc_pkg::PDC_SRC_INT;
    else if (sel == `PDC_SEL_EXT)
      kind = pdc_pkg::PDC_SRC_EXT;
    else if (sel == `PDC_SEL_PLL)
      kind = pdc_pkg::PDC_SRC_PLL;
    return kind;
  endfunction

  // terminal count; zero and one both give one tick per source edge
  function automatic logic [7:0] divLimit(input logic [7:0] div);
    return (div == 8'h00) ? 8'h00 : div - 8'h01;
  endfunction

  // ==========================================================
  // async input synchroniser and edge filter

  logic [NASYNC-1:0] asyncIn;
  logic [NASYNC-1:0] syncA_reg;
  logic [NASYNC-1:0] syncB_reg;
  logic [NASYNC-1:0] syncC_reg;
  logic [NASYNC-1:0] filt_reg;
  logic [NASYNC-1:0] agree;
  logic [NASYNC-1:0] riseEdge;

  assign asyncIn = {scanStrapLevel, testStrapLevel, bootStrapLevel,
                    pllIn, extOscIn, intOscIn, ringOscIn};
  // syncA only feeds syncB; the filter looks at the later two stages
  assign agree = ~(syncB_reg ^ syncC_reg);
  assign riseEdge = agree & syncB_reg & ~filt_reg;

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      syncA_reg <= '0;
      syncB_reg <= '0;
      syncC_reg <= '0;
      filt_reg <= '0;
    end
    else if (clkEn)
    begin
      syncA_reg <= asyncIn;
      syncB_reg <= syncA_reg;
      syncC_reg <= syncB_reg;
      filt_reg <= (agree & syncB_reg) | (~agree & filt_reg);
    end
  end

  // ==========================================================
  // strap capture, once after reset release

  logic [2:0] settle_reg;
  logic captured_reg;
  logic [2:0] strap_reg;
  logic [7:0] modeStatus;

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      settle_reg <= 3'h0;
      captured_reg <= 1'b0;
      strap_reg <= 3'h0;
    end
    else if (clkEn && !captured_reg)
    begin
      if (settle_reg == `PDC_STRAP_SETTLE)
      begin
        captured_reg <= 1'b1; // RULE_01
        strap_reg <= filt_reg[6:4];
      end
      else
        settle_reg <= settle_reg + 3'h1;
    end
  end

  always_comb
  begin
    modeStatus = 8'h00; // RULE_02
    modeStatus[`PDC_SCAN_BIT] = strap_reg[2]; // RULE_03
    modeStatus[`PDC_TEST_BIT] = strap_reg[1];
    modeStatus[`PDC_BOOT_BIT] = strap_reg[0];
  end

  // ==========================================================
  // configuration registers, even port in the low half

  logic [2:0] srcSel_reg [NPORT];
  logic [7:0] divVal_reg [NPORT];
  logic [2:0] srcSel_next [NPORT];
  logic [7:0] divVal_next [NPORT];
  logic [NPORT-1:0] cfgChange;
  logic [1:0] wrIdx;

  assign wrIdx = cfgIndex(regAddr);

  always_comb
  begin
    for (int p = 0; p < NPORT; p++)
    begin
      srcSel_next[p] = srcSel_reg[p];
      divVal_next[p] = divVal_reg[p];
      cfgChange[p] = 1'b0;
      if (regWrStb && wrIdx == 2'(p / 2))
      begin
        if (p % 2 == 0)
        begin
          srcSel_next[p] = regWrData[`PDC_LO_SEL_LSB +: 3]; // RULE_07 RULE_12 RULE_17
          divVal_next[p] = regWrData[`PDC_LO_DIV_LSB +: 8]; // RULE_13 RULE_18
        end
        else
        begin
          srcSel_next[p] = regWrData[`PDC_HI_SEL_LSB +: 3]; // RULE_05 RULE_10 RULE_15
          divVal_next[p] = regWrData[`PDC_HI_DIV_LSB +: 8]; // RULE_06 RULE_11 RULE_16
        end
        cfgChange[p] = (srcSel_next[p] != srcSel_reg[p]) ||
                       (divVal_next[p] != divVal_reg[p]);
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      for (int p = 0; p < NPORT; p++)
      begin
        srcSel_reg[p] <= `PDC_SEL_RST;
        divVal_reg[p] <= DIV_RST[p];
      end
    end
    else if (clkEn)
    begin
      for (int p = 0; p < NPORT; p++)
      begin
        srcSel_reg[p] <= srcSel_next[p]; // RULE_04 RULE_09 RULE_14
        divVal_reg[p] <= divVal_next[p];
      end
    end
  end

  // ==========================================================
  // per-port dividers
  // output is a one-cycle enable, so it cannot be a runt; a change of
  // source or divider restarts the count, trading phase for cleanliness

  logic [7:0] cnt_reg [NPORT];
  logic [NPORT-1:0] srcEdge;

  always_comb
  begin
    for (int p = 0; p < NPORT; p++)
    begin
      srcEdge[p] = 1'b0;
      unique case (srcKind(srcSel_reg[p]))
        pdc_pkg::PDC_SRC_RING: srcEdge[p] = riseEdge[0];
        pdc_pkg::PDC_SRC_BUS: srcEdge[p] = 1'b1; // RULE_08
        pdc_pkg::PDC_SRC_INT: srcEdge[p] = riseEdge[1];
        pdc_pkg::PDC_SRC_EXT: srcEdge[p] = riseEdge[2];
        pdc_pkg::PDC_SRC_PLL: srcEdge[p] = riseEdge[3];
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      for (int p = 0; p < NPORT; p++)
        cnt_reg[p] <= 8'h00;
      dbClkTick <= '0;
    end
    else if (clkEn)
    begin
      for (int p = 0; p < NPORT; p++)
      begin
        if (cfgChange[p])
        begin
          cnt_reg[p] <= 8'h00; // RULE_20
          dbClkTick[p] <= 1'b0;
        end
        else if (srcEdge[p] && cnt_reg[p] >= divLimit(divVal_reg[p]))
        begin
          cnt_reg[p] <= 8'h00; // RULE_19
          dbClkTick[p] <= 1'b1;
        end
        else
        begin
          if (srcEdge[p])
            cnt_reg[p] <= cnt_reg[p] + 8'h01;
          dbClkTick[p] <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // read back, data valid only in the cycle after the strobe

  function automatic logic [31:0] packCfg(input int k);
    logic [31:0] w;
    w = 32'h00000000;
    w[`PDC_LO_SEL_LSB +: 3] = srcSel_reg[2 * k];
    w[`PDC_LO_DIV_LSB +: 8] = divVal_reg[2 * k];
    w[`PDC_HI_SEL_LSB +: 3] = srcSel_reg[2 * k + 1];
    w[`PDC_HI_DIV_LSB +: 8] = divVal_reg[2 * k + 1];
    return w;
  endfunction

  logic [31:0] rdMux;

  always_comb
  begin
    rdMux = 32'h00000000;
    if (regAddr == `PDC_ADDR_MODE_STATUS)
      rdMux = {24'h000000, modeStatus}; // RULE_02
    else if (wrIdx != 2'h3)
      rdMux = packCfg(int'(wrIdx));
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      regRdData <= 32'h00000000;
    else if (clkEn)
      regRdData <= regRdStb ? rdMux : 32'h00000000;
  end

  // ==========================================================
  // checks

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  property p_strap_hold;
    captured_reg && clkEn |=> captured_reg && $stable(strap_reg);
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("strap status changed"); // RULE_01

  property p_strap_capture;
    clkEn && !captured_reg && settle_reg == `PDC_STRAP_SETTLE
      |=> captured_reg && modeStatus[2:0] == $past(filt_reg[6:4]);
  endproperty
  a_strap_capture: assert property (p_strap_capture) else $error("strap bits misplaced"); // RULE_03

  property p_status_read;
    clkEn && regRdStb && regAddr == `PDC_ADDR_MODE_STATUS
      |=> regRdData[31:8] == 24'h000000 && regRdData[7:0] == $past(modeStatus);
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read wrong"); // RULE_02

  sequence s_cfg_write(logic [31:0] a);
    clkEn && regWrStb && regAddr == a;
  endsequence

  sequence s_cfg_read(logic [31:0] a);
    clkEn && regRdStb && regAddr == a && !regWrStb;
  endsequence

  // reserved bits 31:27 and 15:11 must read back as zero
  property p_ab_roundtrip;
    s_cfg_write(`PDC_ADDR_DB_CLOCK_AB) ##1 s_cfg_read(`PDC_ADDR_DB_CLOCK_AB)
      |=> regRdData == ($past(regWrData, 2) & 32'h07FF07FF);
  endproperty
  a_ab_roundtrip: assert property (p_ab_roundtrip) else $error("ab field mismatch"); // RULE_04

  property p_cd_roundtrip;
    s_cfg_write(`PDC_ADDR_DB_CLOCK_CD) ##1 s_cfg_read(`PDC_ADDR_DB_CLOCK_CD)
      |=> regRdData == ($past(regWrData, 2) & 32'h07FF07FF);
  endproperty
  a_cd_roundtrip: assert property (p_cd_roundtrip) else $error("cd field mismatch"); // RULE_09

  property p_ef_roundtrip;
    s_cfg_write(`PDC_ADDR_DB_CLOCK_EF) ##1 s_cfg_read(`PDC_ADDR_DB_CLOCK_EF)
      |=> regRdData == ($past(regWrData, 2) & 32'h07FF07FF);
  endproperty
  a_ef_roundtrip: assert property (p_ef_roundtrip) else $error("ef field mismatch"); // RULE_14

  property p_b_fields;
    s_cfg_write(`PDC_ADDR_DB_CLOCK_AB)
      |=> srcSel_reg[1] == $past(regWrData[26:24]) && divVal_reg[1] == $past(regWrData[23:16]);
  endproperty
  a_b_fields: assert property (p_b_fields) else $error("port b fields wrong"); // RULE_05

  generate
    for (genvar g = 0; g < NPORT; g++)
    begin : g_chk
      property p_bus_undivided;
        clkEn && srcSel_reg[g] == `PDC_SEL_BUS && divVal_reg[g] <= 8'h01 && !cfgChange[g]
          |=> dbClkTick[g];
      endproperty
      a_bus_undivided: assert property (p_bus_undivided) else $error("bus source lost"); // RULE_08

      property p_div_gap;
        clkEn && dbClkTick[g] && divVal_reg[g] >= 8'h02 |=> !dbClkTick[g];
      endproperty
      a_div_gap: assert property (p_div_gap) else $error("divider too fast"); // RULE_19

      property p_change_quiet;
        clkEn && cfgChange[g] |=> !dbClkTick[g] && cnt_reg[g] == 8'h00;
      endproperty
      a_change_quiet: assert property (p_change_quiet) else $error("tick on reprogram"); // RULE_20
    end
  endgenerate

endmodule

/* File: tb/pdc_far_side_model.sv */
/*
  far side of the debounce clock block: four free-running source
  oscillators and the three boot strap pins.
  assumes a system clock at least eight times faster than any source here.
*/
`timescale 1ns/100ps

// ==========================================================
// sources and straps
module pdc_far_side_model #(
  parameter real RING_HALF = 100.0,
  parameter real INT_HALF = 40.0,
  parameter real EXT_HALF = 60.0,
  parameter real PLL_HALF = 28.0,
  parameter logic [2:0] STRAPS = 3'h5
)(
  output logic ringOscIn,
  output logic intOscIn,
  output logic extOscIn,
  output logic pllIn,
  output logic bootStrapLevel,
  output logic testStrapLevel,
  output logic scanStrapLevel
);
  // oscillators run free, they are not gated between uses
  initial
  begin
    ringOscIn = 1'b0;
    forever #(RING_HALF) ringOscIn = ~ringOscIn;
  end
  initial
  begin
    intOscIn = 1'b0;
    forever #(INT_HALF) intOscIn = ~intOscIn;
  end
  initial
  begin
    extOscIn = 1'b0;
    forever #(EXT_HALF) extOscIn = ~extOscIn;
  end
  initial
  begin
    pllIn = 1'b0;
    forever #(PLL_HALF) pllIn = ~pllIn;
  end
  // straps held steady from time zero so the boot capture sees settled pins
  assign bootStrapLevel = STRAPS[0];
  assign testStrapLevel = STRAPS[1];
  assign scanStrapLevel = STRAPS[2];
endmodule

/* File: tb/pdc_port_debounce_clock_select_tb_top.sv */
/*
  self-checking bench for the port debounce clock select block.
  assumes the far side model drives sources and straps; clkEn is dropped
  once, to check that a write is frozen out.
*/
`timescale 1ns/100ps
`include "pdc_consts.svh"

// ==========================================================
// bench top
module pdc_port_debounce_clock_select_tb_top;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic clkEn = 1'b1;
  logic [31:0] regAddr = 32'h0;
  logic [31:0] regWrData = 32'h0;
  logic regWrStb = 1'b0;
  logic regRdStb = 1'b0;
  logic [31:0] regRdData;
  logic ringOsc, intOsc, extOsc, pllOsc, bootLvl, testLvl, scanLvl;
  logic [5:0] dbClkTick;
  int nFail = 0;
  int compares = 0;
  logic [31:0] cfgAddr [3] = '{`PDC_ADDR_DB_CLOCK_AB, `PDC_ADDR_DB_CLOCK_CD,
    `PDC_ADDR_DB_CLOCK_EF};
  // even ports divide by 2, odd by 3, except E by 1 and F by 0
  logic [31:0] cfgVal [3] = '{32'hFC03FC02, 32'hFC03FC02, 32'hFC00FC01};
  int tickExp [6] = '{30, 20, 30, 20, 60, 60};
  logic [2:0] srcCode [5] = '{3'h0, 3'h3, `PDC_SEL_INT, `PDC_SEL_EXT, `PDC_SEL_PLL};
  int srcLo [5] = '{4, 4, 11, 7, 16};
  int srcHi [5] = '{6, 6, 13, 9, 18};
  int n;

  always #2 sys_clk = ~sys_clk;

  // straps not symmetric, so a swap of scan and boot bits shows up
  pdc_far_side_model #(.STRAPS(3'h6)) farSide (
    .ringOscIn(ringOsc),
    .intOscIn(intOsc),
    .extOscIn(extOsc),
    .pllIn(pllOsc),
    .bootStrapLevel(bootLvl),
    .testStrapLevel(testLvl),
    .scanStrapLevel(scanLvl)
  );

  pdc_port_debounce_clock_select DUT (
    .sys_clk(sys_clk),
    .reset(reset),
    .clkEn(clkEn),
    .regAddr(regAddr),
    .regWrData(regWrData),
    .regWrStb(regWrStb),
    .regRdStb(regRdStb),
    .regRdData(regRdData),
    .ringOscIn(ringOsc),
    .intOscIn(intOsc),
    .extOscIn(extOsc),
    .pllIn(pllOsc),
    .bootStrapLevel(bootLvl),
    .testStrapLevel(testLvl),
    .scanStrapLevel(scanLvl),
    .dbClkTick(dbClkTick)
  );

  // ==========================================================
  // tasks
  task automatic testDone;
    $display("compares %0d mismatches %0d", compares, nFail);
    if (nFail == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chkReg(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      nFail++;
      $display("ERROR %0t read %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chkCnt(input int got, input int lo, input int hi);
    compares++;
    if (got < lo || got > hi)
    begin
      nFail++;
      $display("ERROR %0t tick count %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    regWrStb <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge sys_clk);
    regWrStb <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe edge
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    regRdStb <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRdStb <= 1'b0;
    #1 chkReg(regRdData, exp);
  endtask

  // write then read on the very next edge, no idle cycle between strobes
  task automatic wrRd(input logic [31:0] a, input logic [31:0] d, input logic [31:0] exp);
    @(posedge sys_clk);
    regWrStb <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge sys_clk);
    regWrStb <= 1'b0;
    regRdStb <= 1'b1;
    @(posedge sys_clk);
    regRdStb <= 1'b0;
    #1 chkReg(regRdData, exp);
  endtask

  task automatic cnt(input int p, input int cyc, output int k);
    k = 0;
    repeat (cyc)
    begin
      @(posedge sys_clk);
      #1;
      if (dbClkTick[p] === 1'b1)
        k++;
    end
  endtask

  // ==========================================================
  // tests
  initial
  begin
    repeat (20) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (10) @(posedge sys_clk);
    rd(`PDC_ADDR_DB_CLOCK_AB, 32'h00010001);
    rd(`PDC_ADDR_DB_CLOCK_CD, 32'h00010001);
    rd(`PDC_ADDR_DB_CLOCK_EF, 32'h00000001);
    rd(`PDC_ADDR_MODE_STATUS, 32'h00000006);
    wr(`PDC_ADDR_MODE_STATUS, 32'hFFFFFFFF);
    rd(`PDC_ADDR_MODE_STATUS, 32'h00000006);
    wr(32'h40000088, 32'hFFFFFFFF);
    rd(32'h40000088, 32'h00000000);
    rd(`PDC_ADDR_DB_CLOCK_AB, 32'h00010001);
    $display("test reset and status done");
    for (int r = 0; r < 3; r++)
    begin
      wrRd(cfgAddr[r], cfgVal[r], cfgVal[r] & 32'h07FF07FF);
      repeat (8) @(posedge sys_clk);
      for (int h = 0; h < 2; h++)
      begin
        cnt(2 * r + h, 60, n);
        chkCnt(n, tickExp[2 * r + h], tickExp[2 * r + h]);
      end
    end
    $display("test field layout and bus source done");
    // async sources are sampled, so allow one edge of slack per window
    for (int s = 0; s < 5; s++)
    begin
      wr(`PDC_ADDR_DB_CLOCK_AB, {21'h0, srcCode[s], 8'h01});
      repeat (20) @(posedge sys_clk);
      cnt(0, 240, n);
      chkCnt(n, srcLo[s], srcHi[s]);
    end
    $display("test source select done");
    // a write strobe seen while the enable is low must leave port A on PLL, div 1
    @(posedge sys_clk);
    clkEn <= 1'b0;
    wr(`PDC_ADDR_DB_CLOCK_AB, 32'h00000000);
    clkEn <= 1'b1;
    rd(`PDC_ADDR_DB_CLOCK_AB, 32'h00000701);
    $display("test clock enable freeze done");
    wrRd(`PDC_ADDR_DB_CLOCK_EF, 32'h04040504, 32'h04040504);
    repeat (8) @(posedge sys_clk);
    cnt(5, 60, n);
    chkCnt(n, 15, 15);
    $display("test reprogram done");
    testDone;
  end

  // whole sequence needs under 3000 cycles, so 25000 means a hang
  initial
  begin
    #100000;
    nFail++;
    $display("ERROR %0t watchdog expired", $time);
    testDone;
  end
endmodule
